// ---- verilog/gpmx_pkg.sv ----
// gpmx_pkg: constants and carrier types for the gpio port and pin function mux
// assumes a 20 MHz core clock and a 32-bit classic wishbone register bus
package gpmx_pkg;

  // core clock and fixed clock output
  localparam int unsigned GPMX_CLK_HZ  = 20_000_000;
  localparam int unsigned GPMX_FIXED_CLOCK_OUT_HZ = 2_560_000;
  // toggle accumulator: two toggles per output period
  localparam int unsigned GPMX_FIXED_CLOCK_OUT_INC = 2 * GPMX_FIXED_CLOCK_OUT_HZ / 10_000;
  localparam int unsigned GPMX_FIXED_CLOCK_OUT_MOD = GPMX_CLK_HZ / 10_000;
  localparam int unsigned GPMX_ACC_W    = 12;

  // pin counts
  localparam int unsigned GPMX_NPINS  = 9;
  localparam int unsigned GPMX_NPORTS = 3;

  // register byte addresses
  localparam logic [31:0] GPMX_CON0_ADDR = 32'hFFFF_0D00;
  localparam logic [31:0] GPMX_CON1_ADDR = 32'hFFFF_0D04;
  localparam logic [31:0] GPMX_CON2_ADDR = 32'hFFFF_0D08;
  localparam logic [31:0] GPMX_DAT0_ADDR = 32'hFFFF_0D20;
  localparam logic [31:0] GPMX_DAT1_ADDR = 32'hFFFF_0D24;
  localparam logic [31:0] GPMX_DAT2_ADDR = 32'hFFFF_0D28;
  localparam logic [31:0] GPMX_SET0_ADDR = 32'hFFFF_0D30;
  localparam logic [31:0] GPMX_SET1_ADDR = 32'hFFFF_0D34;
  localparam logic [31:0] GPMX_SET2_ADDR = 32'hFFFF_0D38;
  localparam logic [31:0] GPMX_CLR0_ADDR = 32'hFFFF_0D40;
  localparam logic [31:0] GPMX_CLR1_ADDR = 32'hFFFF_0D44;
  localparam logic [31:0] GPMX_CLR2_ADDR = 32'hFFFF_0D48;

  // function select reset values
  localparam logic [31:0] GPMX_CON0_RST = 32'h1110_0000;
  localparam logic [31:0] GPMX_CON1_RST = 32'h1000_0000;
  localparam logic [31:0] GPMX_CON2_RST = 32'h0100_0000;

  // function select fields
  localparam int unsigned GPMX_FS_STRIDE   = 4;
  localparam int unsigned GPMX_HV_A_EN_BIT = 20;
  localparam int unsigned GPMX_HV_B_EN_BIT = 24;
  localparam int unsigned GPMX_LIN_RECEIVE_INTERNAL_BIT   = 16;
  localparam int unsigned GPMX_LIN_TRANSMIT_INTERNAL_BIT   = 20;

  // data register fields
  localparam int unsigned GPMX_DIR_LSB = 24;
  localparam int unsigned GPMX_OUT_LSB = 16;
  localparam int unsigned GPMX_IN_LSB  = 0;

  // implemented bits per port: {port2, port1, port0}
  localparam logic [2:0][7:0] GPMX_PORT_MASK = {8'h33, 8'h03, 8'h7F};

  // internal bit positions
  localparam int unsigned GPMX_HV_A_BIT  = 5;
  localparam int unsigned GPMX_HV_B_BIT  = 6;
  localparam int unsigned GPMX_LIN_RECEIVE_INTERNAL_POS = 4;
  localparam int unsigned GPMX_LIN_TRANSMIT_INTERNAL_POS = 5;

  // external pad bundle
  typedef struct packed {
    logic [8:0] out;
    logic [8:0] oe_n;
  } gpmx_pad_t;

  // alternate function drive from on-chip peripherals
  typedef struct packed {
    logic [8:0] drive;
    logic [8:0] en;
  } gpmx_alt_t;

  // pin to port number
  function automatic logic [1:0] gpmx_pin_port(input int unsigned k);
    gpmx_pin_port = (k < 5) ? 2'd0 : (k < 7) ? 2'd1 : 2'd2;
  endfunction : gpmx_pin_port

  // pin to bit within its port
  function automatic logic [2:0] gpmx_pin_bit(input int unsigned k);
    gpmx_pin_bit = (k < 5) ? 3'(k) : (k < 7) ? 3'(k - 5) : 3'(k - 7);
  endfunction : gpmx_pin_bit

endpackage : gpmx_pkg

// ---- verilog/gpmx_top.sv ----
// gpmx_top: three gpio ports, nine pads, alternate function mux, wishbone slave
// assumes pads come from outside the clock domain; peripherals share clk_i
//
// Summary of operation
// - nine two-way pads in three ports of five, two and two bits
// - after reset every pad is plain gpio until software selects otherwise
// - external interrupts on pads 0, 5, 7, 8 are level, active high
// - each port has function select, dir/data, bit set, bit clear registers
// - during power down every pad keeps its previous output level
// - pad 0 is port bit, external interrupt zero or spi slave select
// - pads 1 to 3 are port bits or spi clock, miso and mosi
// - pad 4 is port bit or a fixed 2.56 MHz clock output
// - port0 bits 5 and 6 are internal two-wire high voltage link lines
// - pad 5 is port bit, interrupt one or uart rx; pad 6 uart tx
// - pad 7 is port bit, interrupt four or readback of the lin pin
// - pad 8 is port bit, interrupt five or direct drive of lin pin
// - port2 bits 4 and 5 are internal lin rx/tx diagnostics; bit 6 reserved
// - port0 function select at 0xffff0d00, read/write, resets to 0x11100000
// - bits 0,4,8,12,16 select alternate function for pads 0 to 4
//
// Local design decision: the Wishbone register port.
`timescale 1ns/100ps
module gpmx_top
  import gpmx_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  input  wire logic [8:0]  pad_i,
  output gpmx_pad_t        pad_o,
  input  wire logic        power_down_i,
  input  wire gpmx_alt_t   alt_i,
  output logic      [8:0]  alt_in_o,
  output logic      [3:0]  ext_irq_o,
  input  wire logic [1:0]  hv_link_i,
  output logic      [1:0]  hv_link_o,
  output logic      [1:0]  hv_link_oe_n_o,
  input  wire logic        lin_receive_internal_i,
  output logic             lin_transmit_internal_o,
  output logic             lin_transmit_internal_en_o,
  output logic             lin_pin_drive_o,
  output logic             lin_pin_drive_en_o,
  output logic             fixed_clock_out_o
);

  logic [31:0]      con [GPMX_NPORTS];
  logic [7:0]       dir [GPMX_NPORTS];
  logic [7:0]       out [GPMX_NPORTS];
  logic [7:0]       pin_in [GPMX_NPORTS];
  logic [8:0]       sync1;
  logic [8:0]       sync2;
  logic [8:0]       fsel;
  logic [8:0]       alt_val;
  logic [8:0]       alt_en;
  logic [8:0]       next_pad_out;
  logic [8:0]       next_pad_oe_n;
  logic [GPMX_ACC_W-1:0] acc;
  logic             fixed_clock_out;
  logic             req;
  logic             wr;
  logic [31:0]      next_dat;

  // write mask from byte selects
  function automatic logic [31:0] byte_mask(input logic [3:0] sel);
    byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : byte_mask

  assign req = cyc_i & stb_i & ~ack_o;
  assign wr  = req & we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pad_i;
      sync2 <= sync1;
    end
  end

  assign ext_irq_o = {sync2[8], sync2[7], sync2[5], sync2[0]};
  assign alt_in_o  = sync2;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      con[0] <= GPMX_CON0_RST;
      con[1] <= GPMX_CON1_RST;
      con[2] <= GPMX_CON2_RST;
    end else if (wr) begin
      case (adr_i)
        GPMX_CON0_ADDR: begin
          con[0] <= (con[0] & ~byte_mask(sel_i)) | (dat_i & byte_mask(sel_i));
        end
        GPMX_CON1_ADDR: begin
          con[1] <= (con[1] & ~byte_mask(sel_i)) | (dat_i & byte_mask(sel_i));
        end
        GPMX_CON2_ADDR: begin
          con[2] <= (con[2] & ~byte_mask(sel_i)) | (dat_i & byte_mask(sel_i));
        end
        default: begin
        end
      endcase
    end
  end

  // direction and output data per port
  generate
    for (genvar p = 0; p < GPMX_NPORTS; p++) begin : g_port
      localparam logic [31:0] DAT_A = GPMX_DAT0_ADDR + 32'(4 * p);
      localparam logic [31:0] SET_A = GPMX_SET0_ADDR + 32'(4 * p);
      localparam logic [31:0] CLR_A = GPMX_CLR0_ADDR + 32'(4 * p);
      localparam logic [7:0]  MASK  = GPMX_PORT_MASK[p];
      logic [7:0] wdir;
      logic [7:0] wout;
      assign wdir = dat_i[GPMX_DIR_LSB +: 8] & MASK;
      assign wout = dat_i[GPMX_OUT_LSB +: 8] & MASK;

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          dir[p] <= '0;
        end else if (wr && adr_i == DAT_A && sel_i[GPMX_DIR_LSB / 8]) begin
          dir[p] <= wdir;
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          out[p] <= '0;
        end else if (wr && sel_i[GPMX_OUT_LSB / 8]) begin
          if (adr_i == DAT_A) begin
            out[p] <= wout;
          end else if (adr_i == SET_A) begin
            out[p] <= out[p] | wout;
          end else if (adr_i == CLR_A) begin
            out[p] <= out[p] & ~wout;
          end
        end
      end
    end
  endgenerate

  // input field from synchronised pads and internal lines
  always_comb begin
    for (int p = 0; p < GPMX_NPORTS; p++) begin
      pin_in[p] = '0;
    end
    for (int unsigned k = 0; k < GPMX_NPINS; k++) begin
      pin_in[gpmx_pin_port(k)][gpmx_pin_bit(k)] = sync2[k];
    end
    pin_in[0][GPMX_HV_A_BIT] = hv_link_i[0];
    pin_in[0][GPMX_HV_B_BIT] = hv_link_i[1];
    pin_in[2][GPMX_LIN_RECEIVE_INTERNAL_POS] = con[2][GPMX_LIN_RECEIVE_INTERNAL_BIT] ? lin_receive_internal_i
                                                       : out[2][GPMX_LIN_RECEIVE_INTERNAL_POS];
    pin_in[2][GPMX_LIN_TRANSMIT_INTERNAL_POS] = out[2][GPMX_LIN_TRANSMIT_INTERNAL_POS];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc  <= '0;
      fixed_clock_out <= 1'b0;
    end else if (acc + GPMX_ACC_W'(GPMX_FIXED_CLOCK_OUT_INC) >= GPMX_ACC_W'(GPMX_FIXED_CLOCK_OUT_MOD)) begin
      acc  <= acc + GPMX_ACC_W'(GPMX_FIXED_CLOCK_OUT_INC) - GPMX_ACC_W'(GPMX_FIXED_CLOCK_OUT_MOD);
      fixed_clock_out <= ~fixed_clock_out;
    end else begin
      acc  <= acc + GPMX_ACC_W'(GPMX_FIXED_CLOCK_OUT_INC);
    end
  end

  // per-pad function mux
  generate
    for (genvar k = 0; k < GPMX_NPINS; k++) begin : g_pin
      localparam logic [1:0] P = gpmx_pin_port(k);
      localparam logic [2:0] B = gpmx_pin_bit(k);
      assign fsel[k] = con[P][GPMX_FS_STRIDE * B];
      if (k == 4) begin : g_fixed_clock_out
        assign alt_val[k] = fixed_clock_out;
        assign alt_en[k]  = 1'b1;
      end else if (k == 7) begin : g_linrd
        // lin pin level onto pad 7
        assign alt_val[k] = lin_receive_internal_i;
        assign alt_en[k]  = 1'b1;
      end else if (k == 5 || k == 8) begin : g_inonly
        // uart rx and lin drive are inputs
        assign alt_val[k] = 1'b0;
        assign alt_en[k]  = 1'b0;
      end else begin : g_periph
        // spi and uart tx from peripherals
        assign alt_val[k] = alt_i.drive[k];
        assign alt_en[k]  = alt_i.en[k];
      end
      assign next_pad_out[k]  = fsel[k] ? alt_val[k] : out[P][B];
      assign next_pad_oe_n[k] = fsel[k] ? ~alt_en[k] : ~dir[P][B];
    end
  endgenerate

  // pads hold their level in power down
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_o.out  <= '0;
      pad_o.oe_n <= '1;
    end else if (!power_down_i) begin
      pad_o.out  <= next_pad_out;
      pad_o.oe_n <= next_pad_oe_n;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hv_link_o      <= '0;
      hv_link_oe_n_o <= '1;
    end else begin
      hv_link_o      <= {out[0][GPMX_HV_B_BIT], out[0][GPMX_HV_A_BIT]};
      hv_link_oe_n_o <= ~({con[0][GPMX_HV_B_EN_BIT], con[0][GPMX_HV_A_EN_BIT]}
                          & {dir[0][GPMX_HV_B_BIT], dir[0][GPMX_HV_A_BIT]});
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lin_transmit_internal_o    <= 1'b0;
      lin_transmit_internal_en_o <= 1'b0;
      lin_pin_drive_o            <= 1'b0;
      lin_pin_drive_en_o         <= 1'b0;
    end else begin
      lin_transmit_internal_o    <= out[2][GPMX_LIN_TRANSMIT_INTERNAL_POS];
      lin_transmit_internal_en_o <= con[2][GPMX_LIN_TRANSMIT_INTERNAL_BIT];
      lin_pin_drive_o            <= sync2[8];
      lin_pin_drive_en_o         <= fsel[8];
    end
  end

  assign fixed_clock_out_o = fixed_clock_out;

  // read mux
  always_comb begin
    next_dat = '0;
    case (adr_i)
      GPMX_CON0_ADDR: next_dat = con[0];
      GPMX_CON1_ADDR: next_dat = con[1];
      GPMX_CON2_ADDR: next_dat = con[2];
      GPMX_DAT0_ADDR: next_dat = {dir[0], out[0], 8'h00, pin_in[0]};
      GPMX_DAT1_ADDR: next_dat = {dir[1], out[1], 8'h00, pin_in[1]};
      GPMX_DAT2_ADDR: next_dat = {dir[2], out[2], 8'h00, pin_in[2]};
      default:        next_dat = '0;
    endcase
  end

  // wishbone answer, one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= req;
      if (req && !we_i) begin
        dat_o <= next_dat;
      end
    end
  end

endmodule : gpmx_top

// ---- tb/gpmx_chk.sv ----
// gpmx_chk: port-level checks on gpmx_top
// assumes bind from the bench top, one clock domain
`timescale 1ns/100ps
module gpmx_chk
  import gpmx_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [31:0] adr_i,
  input wire logic        we_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  input wire logic [8:0]  pad_i,
  input wire gpmx_pad_t   pad_o,
  input wire logic        power_down_i,
  input wire logic [8:0]  alt_in_o,
  input wire logic [3:0]  ext_irq_o,
  input wire logic        fixed_clock_out_o
);
  logic [1:0] up;
  // cycles since reset release, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  a_ack_next: assert property (s_req |=> ack_o)
    else $error("ack missing");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  a_rd_unmap: assert property (
    s_req ##0 (!we_i && adr_i == 32'hFFFF_0D10) |=> dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_pad_hold: assert property (power_down_i |=> $stable(pad_o))
    else $error("pad moved in power down");
  a_irq_sync: assert property (
    up == 2'h3 |-> ext_irq_o == $past({pad_i[8], pad_i[7], pad_i[5], pad_i[0]}, 2))
    else $error("irq level wrong");
  a_alt_sync: assert property (up == 2'h3 |-> alt_in_o == $past(pad_i, 2))
    else $error("synced pad level wrong");
  a_rst_idle: assert property (
    $fell(rst_i) |-> pad_o.oe_n == 9'h1ff && pad_o.out == 9'h000 && !ack_o)
    else $error("pads not idle after reset");
  a_fixed_clock_out_gap: assert property (
    $changed(fixed_clock_out_o) |=> $stable(fixed_clock_out_o)[*2])
    else $error("clock out edge too soon");
endmodule : gpmx_chk

// ---- tb/gpmx_board.sv ----
// gpmx_board: board side of the nine pads
// assumes pull-ups on every pad, drive chosen by the bench
`timescale 1ns/100ps
module gpmx_board
  import gpmx_pkg::*;
(
  input  wire gpmx_pad_t  dev_pad_i,
  input  wire logic [8:0] drv_en_i,
  input  wire logic [8:0] drv_val_i,
  output logic      [8:0] lvl_o
);
  always_comb begin
    for (int k = 0; k < 9; k++) begin
      lvl_o[k] = !dev_pad_i.oe_n[k] ? dev_pad_i.out[k] : drv_en_i[k] ? drv_val_i[k] : 1'b1;
    end
  end
endmodule : gpmx_board

// ---- tb/tb_gpio_ports_pin_function_mux.sv ----
// tb_gpio_ports_pin_function_mux: random and corner tests of gpmx_top
// assumes board model on the pads, bench as wishbone master
`timescale 1ns/100ps
module tb_gpio_ports_pin_function_mux;
  import gpmx_pkg::*;
  logic        clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, power_down_i;
  logic        lin_receive_internal_i, lin_transmit_internal_o;
  logic        lin_transmit_internal_en_o, lin_pin_drive_o;
  logic        lin_pin_drive_en_o, fixed_clock_out_o, pv;
  logic [31:0] adr_i, dat_i, dat_o, q, v;
  logic [3:0]  sel_i, ext_irq_o;
  logic [8:0]  pad_i, alt_in_o, drv_en, drv_val, lv, po;
  logic [1:0]  hv_link_i, hv_link_o, hv_link_oe_n_o;
  gpmx_pad_t   pad_o;
  gpmx_alt_t   alt_i;
  int          error_cnt, check_count, cyc_cnt, n;
  gpmx_top DUT (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i,
    .stb_i, .ack_o, .pad_i, .pad_o, .power_down_i, .alt_i, .alt_in_o, .ext_irq_o,
    .hv_link_i, .hv_link_o, .hv_link_oe_n_o, .lin_receive_internal_i,
    .lin_transmit_internal_o, .lin_transmit_internal_en_o, .lin_pin_drive_o,
    .lin_pin_drive_en_o, .fixed_clock_out_o);
  gpmx_board u_brd (.dev_pad_i(pad_o), .drv_en_i(drv_en), .drv_val_i(drv_val), .lvl_o(pad_i));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    if (k >= 20) error_cnt++;
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask : wb
  function automatic logic [8:0] lvl();
    return (drv_en & drv_val) | ~drv_en;
  endfunction : lvl
  task automatic wt(input int k);
    repeat (k) @(posedge clk_i);
  endtask : wt
  initial begin
    {rst_i, we_i, cyc_i, stb_i, power_down_i, lin_receive_internal_i} = 6'b100000;
    {adr_i, dat_i, drv_en, drv_val, hv_link_i} = '0;
    sel_i = 4'hf;
    alt_i = '0;
    q = $urandom(9);
    wt(6);
    rst_i <= 1'b0;
    wb(GPMX_CON0_ADDR, 0, 0);
    chk(q, 32'h1110_0000);
    wb(GPMX_CON1_ADDR, 0, 0);
    chk(q, 32'h1000_0000);
    wb(GPMX_CON2_ADDR, 0, 0);
    chk(q, 32'h0100_0000);
    chk(pad_o.oe_n, 9'h1ff);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      drv_en <= 9'($urandom);
      drv_val <= 9'($urandom);
      hv_link_i <= 2'($urandom);
      alt_i <= gpmx_alt_t'(18'($urandom));
      wt(4);
      lv = lvl();
      chk(pad_o.oe_n, 9'h1ff);
      wb(GPMX_DAT0_ADDR, 0, 0);
      chk(q, {25'h0, hv_link_i[1:0], lv[4:0]});
      wb(GPMX_DAT1_ADDR, 0, 0);
      chk(q, {30'h0, lv[6:5]});
      wb(GPMX_DAT2_ADDR, 0, 0);
      chk(q, {30'h0, lv[8:7]});
      chk(ext_irq_o, {lv[8], lv[7], lv[5], lv[0]});
    end
    $display("input test done");
    wb(GPMX_DAT0_ADDR, 1, 32'h1F00_0000);
    po = 9'h000;
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      wb(GPMX_SET0_ADDR, 1, {8'h00, v[7:0], 16'h0000});
      po[4:0] = po[4:0] | v[4:0];
      wt(2);
      chk(pad_o.out[4:0], po[4:0]);
      wb(GPMX_CLR0_ADDR, 1, {8'h00, v[15:8], 16'h0000});
      po[4:0] = po[4:0] & ~v[12:8];
      wt(2);
      chk(pad_o.out[4:0], po[4:0]);
    end
    chk(pad_o.oe_n[4:0], 5'h00);
    power_down_i <= 1'b1;
    wb(GPMX_SET0_ADDR, 1, 32'h001F_0000);
    wt(3);
    chk(pad_o.out[4:0], po[4:0]);
    power_down_i <= 1'b0;
    wt(3);
    chk(pad_o.out[4:0], 5'h1f);
    wb(GPMX_CLR0_ADDR, 1, 32'h00FF_0000);
    $display("output test done");
    wb(GPMX_CON0_ADDR, 1, 32'h1111_1111);
    wt(3);
    chk(pad_o.out[3:0], alt_i.drive[3:0]);
    chk(pad_o.oe_n[4:0], {1'b0, ~alt_i.en[3:0]});
    n = 0;
    pv = pad_o.out[4];
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk_i);
      if (pad_o.out[4] !== pv) n++;
      pv = pad_o.out[4];
    end
    chk(n >= 511 && n <= 513, 1);
    wb(GPMX_DAT0_ADDR, 1, 32'h6000_0000);
    wb(GPMX_SET0_ADDR, 1, 32'h0060_0000);
    wt(2);
    chk({hv_link_oe_n_o, hv_link_o}, 4'h3);
    $display("port0 function test done");
    lin_receive_internal_i <= 1'($urandom);
    wb(GPMX_CON1_ADDR, 1, 32'h0000_0011);
    wb(GPMX_CON2_ADDR, 1, 32'h0011_0011);
    wb(GPMX_SET2_ADDR, 1, 32'h0020_0000);
    wt(3);
    lv = lvl();
    chk({pad_o.out[6], pad_o.oe_n[6:5]}, {alt_i.drive[6], ~alt_i.en[6], 1'b1});
    chk({pad_o.out[7], pad_o.oe_n[7]}, {lin_receive_internal_i, 1'b0});
    chk({lin_pin_drive_en_o, lin_pin_drive_o, pad_o.oe_n[8]}, {2'b11 & {1'b1, lv[8]}, 1'b1});
    chk({lin_transmit_internal_en_o, lin_transmit_internal_o}, 2'h3);
    wb(GPMX_DAT2_ADDR, 0, 0);
    chk(q, {16'h0020, 10'h0, 1'b1, lin_receive_internal_i, 2'h0, lv[8], lin_receive_internal_i});
    wb(32'hFFFF_0D10, 1, 32'hFFFF_FFFF);
    wb(32'hFFFF_0D10, 0, 0);
    chk(q, 32'h0000_0000);
    $display("port1 port2 test done");
    finish_test();
  end
endmodule : tb_gpio_ports_pin_function_mux
bind gpmx_top gpmx_chk u_chk (.clk_i, .rst_i, .adr_i, .we_i, .cyc_i, .stb_i, .ack_o,
  .dat_o, .pad_i, .pad_o, .power_down_i, .alt_in_o, .ext_irq_o, .fixed_clock_out_o);
